// File: logic/ptp_rtc_rx_timestamp_buffer.sv
/*
 * Network time counter with receive precision-time frame store and
 * an APB register slave.
 * Assumes the receive splitter already filtered frames, and that the timer
 * and receive clocks are pins far slower than the system clock.
 */
`timescale 1ns/1ps
`default_nettype none
module ptp_rtc_rx_timestamp_buffer
	import rtc_ptp_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	// Timer reference clock pin
	input  wire logic        rtc_clk_i,
	// Receive splitter
	input  wire logic        rx_clk_i,
	input  wire logic        rx_clk_en_i,
	input  wire logic [7:0]  rx_data_i,
	input  wire logic        rx_data_valid_i,
	input  wire logic        rx_frame_good_i,
	input  wire logic        rx_frame_bad_i,
	// APB slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output var  logic [31:0] prdata_o,
	output var  logic        pready_o,
	output var  logic        pslverr_o,
	// Event
	output var  logic        rx_ptp_irq_o
);

	// ------------------------------------------------------------------
	// Pin synchronisers and edge finders
	// ------------------------------------------------------------------
	pins_type pins;
	pins_type sync1;
	pins_type sync2;
	logic     rtc_prev;
	logic     rx_prev;
	logic     rtc_tick;
	logic     rx_act;

	assign pins = '{
		rtc_clk: rtc_clk_i,
		rx_clk:  rx_clk_i,
		rx_en:   rx_clk_en_i,
		data:    rx_data_i,
		valid:   rx_data_valid_i,
		good:    rx_frame_good_i,
		bad:     rx_frame_bad_i
	};

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sync1 <= '0;
			sync2 <= '0;
		end else begin
			sync1 <= pins;
			sync2 <= sync1;
		end
	end

	// Edge finders read only the second stage
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rtc_prev <= 1'b0;
			rx_prev  <= 1'b0;
		end else begin
			rtc_prev <= sync2.rtc_clk;
			rx_prev  <= sync2.rx_clk;
		end
	end

	assign rtc_tick = sync2.rtc_clk & ~rtc_prev; // R16
	// Data travel with the clock, so they line up with its found edge
	assign rx_act = sync2.rx_clk & ~rx_prev & sync2.rx_en; // R17

	// ------------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------------
	logic        acc_done;
	logic        wr_done;
	logic        is_buf;
	logic        mapped;
	logic        step_req;
	logic        sample_req;
	logic [31:0] next_prdata;

	assign acc_done   = psel_i & penable_i & pready_o;
	assign wr_done    = acc_done & pwrite_i;
	assign is_buf     = paddr_i[BUF_SEL_BIT];
	// Buffer window and control block both take whole aligned words only
	assign mapped     = (paddr_i[1:0] == 2'h0)
		&& (is_buf || paddr_i <= LATEST_ADDR);
	assign step_req   = wr_done && paddr_i == CMD_ADDR && pwdata_i[CMD_STEP_BIT];
	assign sample_req = wr_done && paddr_i == CMD_ADDR && pwdata_i[CMD_SAMPLE_BIT];

	// ------------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------------
	logic [31:0] inc;
	logic [31:0] step_ns;
	logic [47:0] step_sec;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			inc      <= INC_RESET;
			step_ns  <= '0;
			step_sec <= '0;
		end else if (wr_done) begin
			case (paddr_i)
				INC_ADDR:      inc <= pwdata_i; // R13
				STEP_NS_ADDR:  step_ns <= pwdata_i;
				STEP_SLO_ADDR: step_sec[31:0] <= pwdata_i;
				STEP_SHI_ADDR: step_sec[47:32] <= pwdata_i[15:0];
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Time counter
	// ------------------------------------------------------------------
	logic [31:0] ns;
	logic [FRAC_BITS-1:0] frac;
	logic [47:0] sec;
	logic [52:0] run_sum;
	logic [32:0] run_ns;
	logic signed [33:0] step_sum;

	// Fraction sits below the nanosecond point, so one add serves both
	assign run_sum = {1'b0, ns, frac} + {21'h0, inc}; // R11 R12
	assign run_ns  = run_sum[52:FRAC_BITS];
	// Step range is one second either way; larger values are not folded
	assign step_sum = $signed({2'b00, ns}) + $signed({{2{step_ns[31]}}, step_ns});

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ns   <= '0; // R18
			frac <= '0;
			sec  <= '0;
		end else if (step_req) begin
			// Step wins over a tick in the same cycle
			if (step_sum < 0) begin
				ns  <= 32'(step_sum + $signed({1'b0, NS_PER_SEC})); // R21
				sec <= sec + step_sec - 48'h1;
			end else if (step_sum >= $signed({1'b0, NS_PER_SEC})) begin
				ns  <= 32'(step_sum - $signed({1'b0, NS_PER_SEC})); // R21
				sec <= sec + step_sec + 48'h1;
			end else begin
				ns  <= step_sum[31:0]; // R14
				sec <= sec + step_sec;
			end
		end else if (rtc_tick) begin
			frac <= run_sum[FRAC_BITS-1:0];
			if (run_ns >= NS_PER_SEC) begin
				ns  <= 32'(run_ns - NS_PER_SEC); // R8
				// Plain modulo add: wraps only past all ones
				sec <= sec + 48'h1; // R9 R10
			end else begin
				ns  <= run_ns[31:0];
			end
		end
	end

	// ------------------------------------------------------------------
	// Software snapshot
	// ------------------------------------------------------------------
	logic [31:0] snap_ns;
	logic [47:0] snap_sec;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			snap_ns  <= '0;
			snap_sec <= '0;
		end else if (sample_req) begin
			snap_ns  <= ns; // R15
			snap_sec <= sec;
		end
	end

	// ------------------------------------------------------------------
	// Receive frame writer
	// ------------------------------------------------------------------
	typedef enum logic [4:0] {
		RX_IDLE  = 5'h01,
		RX_DATA  = 5'h02,
		RX_STAMP = 5'h04,
		RX_LEN   = 5'h08,
		RX_DONE  = 5'h10
	} rx_state_type;

	rx_state_type        rx_state;
	logic [SLOT_AW-1:0]  latest;
	logic                any_stored;
	logic [SLOT_AW-1:0]  wr_slot;
	logic [7:0]          byte_cnt;
	logic [15:0]         frame_len;
	logic [31:0]         stamp;
	mem_wr_type          mem_wr;
	logic [31:0]         mem_rd_data;

	// Next slot after the newest is the oldest once the ring has filled
	assign wr_slot = any_stored ? latest + 4'h1 : 4'h0; // R4

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rx_state <= RX_IDLE;
		end else begin
			case (rx_state)
				RX_IDLE: begin
					if (rx_act && sync2.valid) begin
						rx_state <= RX_DATA;
					end
				end
				RX_DATA: begin
					if (rx_act && sync2.good) begin
						rx_state <= RX_STAMP;
					end else if (rx_act && sync2.bad) begin
						// Slot stays unpublished and is reused by the next frame
						rx_state <= RX_IDLE;
					end
				end
				RX_STAMP: rx_state <= RX_LEN;
				RX_LEN:   rx_state <= RX_DONE;
				RX_DONE:  rx_state <= RX_IDLE;
				default:  rx_state <= RX_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			byte_cnt  <= '0;
			frame_len <= '0;
			stamp     <= '0;
		end else if (rx_state == RX_IDLE && rx_act && sync2.valid) begin
			// Same clock domain, so the whole word is copied in one edge
			stamp     <= ns; // R6 R20
			byte_cnt  <= 8'h1;
			frame_len <= 16'h1;
		end else if (rx_state == RX_DATA && rx_act && sync2.valid) begin
			if (byte_cnt != DATA_BYTES) byte_cnt <= byte_cnt + 8'h1;
			// Length counts past the stored area so software sees the true size
			if (frame_len != 16'hFFFF) frame_len <= frame_len + 16'h1;
		end
	end

	// Bytes past the data area are counted but not stored
	always_comb begin
		mem_wr = '0;
		case (rx_state)
			RX_IDLE, RX_DATA: begin
				mem_wr.we = rx_act && sync2.valid
					&& (rx_state == RX_IDLE || byte_cnt != DATA_BYTES); // R1
				mem_wr.addr = (rx_state == RX_IDLE) ? {wr_slot, 5'h00}
					: {wr_slot, byte_cnt[6:2]};
				mem_wr.be = (rx_state == RX_IDLE) ? 4'h1
					: 4'(4'h1 << byte_cnt[1:0]);
				mem_wr.data = {4{sync2.data}};
			end
			RX_STAMP: begin
				mem_wr.we   = 1'b1;
				mem_wr.addr = {wr_slot, STAMP_WORD};
				mem_wr.be   = 4'hF;
				mem_wr.data = stamp; // R6
			end
			RX_LEN: begin
				mem_wr.we   = 1'b1;
				mem_wr.addr = {wr_slot, LEN_WORD};
				mem_wr.be   = 4'hF;
				mem_wr.data = {16'h0, frame_len};
			end
			default: mem_wr = '0;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rx_ptp_irq_o <= 1'b0; // R18
		end else begin
			// Stamp and length are already in memory when this fires
			rx_ptp_irq_o <= (rx_state == RX_DONE); // R2 R7
		end
	end

	// A dropped frame never gets here, so its slot is not published
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			latest     <= '0; // R18
			any_stored <= 1'b0;
		end else if (rx_state == RX_DONE) begin
			latest     <= wr_slot; // R5
			any_stored <= 1'b1;
		end
	end

	ptp_slot_ram u_slot_ram (
		.clk_i     (clk_i),
		.wr_i      (mem_wr),
		.rd_addr_i (paddr_i[MEM_AW+1:2]),
		.rd_data_o (mem_rd_data)
	);

	// ------------------------------------------------------------------
	// APB read and completion
	// ------------------------------------------------------------------
	always_comb begin
		next_prdata = '0;
		if (is_buf) begin
			next_prdata = mem_rd_data; // R3
		end else begin
			case (paddr_i)
				INC_ADDR:      next_prdata = inc;
				STEP_NS_ADDR:  next_prdata = step_ns;
				STEP_SLO_ADDR: next_prdata = step_sec[31:0];
				STEP_SHI_ADDR: next_prdata = {16'h0, step_sec[47:32]};
				SNAP_NS_ADDR:  next_prdata = snap_ns;
				SNAP_SLO_ADDR: next_prdata = snap_sec[31:0];
				SNAP_SHI_ADDR: next_prdata = {16'h0, snap_sec[47:32]};
				LATEST_ADDR:   next_prdata = {23'h0, any_stored, 4'h0, latest}; // R5
				default:       next_prdata = '0;
			endcase
		end
	end

	// One wait state for every access: memory data need the extra cycle
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o  <= '0;
		end else if (psel_i && penable_i && !pready_o) begin
			pready_o  <= 1'b1;
			pslverr_o <= ~mapped;
			prdata_o  <= (pwrite_i || !mapped) ? 32'h0 : next_prdata;
		end else begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
		end
	end

endmodule : ptp_rtc_rx_timestamp_buffer
`default_nettype wire

// File: include/rtc_ptp_pkg.sv
/*
 * Constants, register map and carrier types for the network time counter
 * with receive precision-time frame capture.
 * Assumes a single 200 MHz system clock; every other clock arrives as a pin.
 */
// What this block does
// [R1] Receive store keeps up to 16 whole precision-time frames, one per slot; the code stores only the first 120 bytes of a frame.
// [R2] A dedicated interrupt output pulses after each stored received frame.
// [R3] Host reads every word of every slot over the register bus.
// [R4] Store is circular; a new frame replaces the oldest slot when full.
// [R5] A readable register holds the index of the newest written slot.
// [R6] Frame arrival captures the nanosecond count into that slot's stamp word.
// [R7] Stamp is written before the interrupt fires.
// [R8] Nanosecond field is 32 bits, counts one second, then returns to zero.
// [R9] Seconds field is 48 bits and steps when nanoseconds complete a second.
// [R10] Seconds roll to zero only after reaching all ones.
// [R11] Each reference clock cycle adds the programmed increment, its period.
// [R12] Increment carries 20 fractional nanosecond bits.
// [R13] A new increment written while running applies to later counting.
// [R14] A register lets software step the counter by a large amount.
// [R15] Software can sample the current counter value.
// [R16] Counter advances only on timer reference clock edges.
// [R17] Receive logic acts only on receive clock cycles with the qualifier high.
// [R18] One asynchronous reset initialises counter, pointer and interrupt state.
// [R19] The splitter routes only frames matching the time Length/Type here.
// [R20] Captured nanosecond value crosses into receive logic untorn.
// [R21] A step updates both fields in one cycle with carry or borrow.
package rtc_ptp_pkg;

	// ------------------------------------------------------------------
	// Store geometry
	// ------------------------------------------------------------------
	localparam int SLOT_COUNT     = 16;
	localparam int SLOT_AW        = 4;
	localparam int WORDS_PER_SLOT = 32;
	localparam int WORD_AW        = 5;
	localparam int MEM_AW         = SLOT_AW + WORD_AW;
	localparam int MEM_DEPTH      = SLOT_COUNT * WORDS_PER_SLOT;
	localparam logic [WORD_AW-1:0] STAMP_WORD = 5'h1E;
	localparam logic [WORD_AW-1:0] LEN_WORD   = 5'h1F;
	localparam logic [7:0]         DATA_BYTES = 8'h78;

	// ------------------------------------------------------------------
	// Register map, byte addresses
	// ------------------------------------------------------------------
	localparam logic [11:0] INC_ADDR       = 12'h000;
	localparam logic [11:0] STEP_NS_ADDR   = 12'h004;
	localparam logic [11:0] STEP_SLO_ADDR  = 12'h008;
	localparam logic [11:0] STEP_SHI_ADDR  = 12'h00C;
	localparam logic [11:0] CMD_ADDR       = 12'h010;
	localparam logic [11:0] SNAP_NS_ADDR   = 12'h014;
	localparam logic [11:0] SNAP_SLO_ADDR  = 12'h018;
	localparam logic [11:0] SNAP_SHI_ADDR  = 12'h01C;
	localparam logic [11:0] LATEST_ADDR    = 12'h020;
	localparam int          BUF_SEL_BIT    = 11;
	localparam int          CMD_STEP_BIT   = 0;
	localparam int          CMD_SAMPLE_BIT = 1;
	localparam int          LATEST_VALID_BIT = 8;

	// ------------------------------------------------------------------
	// Counter format and reset values
	// ------------------------------------------------------------------
	localparam int           FRAC_BITS  = 20;
	localparam logic [32:0]  NS_PER_SEC = 33'h03B9ACA00;
	localparam logic [31:0]  INC_RESET  = 32'h0500_0000;

	// ------------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------------
	typedef struct packed {
		logic       rtc_clk;
		logic       rx_clk;
		logic       rx_en;
		logic [7:0] data;
		logic       valid;
		logic       good;
		logic       bad;
	} pins_type;

	typedef struct packed {
		logic               we;
		logic [MEM_AW-1:0]  addr;
		logic [3:0]         be;
		logic [31:0]        data;
	} mem_wr_type;

endpackage : rtc_ptp_pkg

// File: logic/ptp_slot_ram.sv
/*
 * Slot memory for received frames: one byte-enabled write port and one
 * read port whose data come out of a register one cycle after the address.
 * Assumes both ports run on the system clock.
 */
`timescale 1ns/1ps
`default_nettype none
module ptp_slot_ram
	import rtc_ptp_pkg::*;
(
	// Clock
	input  wire logic               clk_i,
	// Write port
	input  wire mem_wr_type         wr_i,
	// Read port
	input  wire logic [MEM_AW-1:0]  rd_addr_i,
	output var  logic [31:0]        rd_data_o
);

	genvar lane;
	generate
		for (lane = 0; lane < 4; lane++) begin : g_lane
			// One array per byte lane keeps each array to a single writer
			logic [7:0] lane_mem [MEM_DEPTH];
			always_ff @(posedge clk_i) begin
				if (wr_i.we && wr_i.be[lane]) begin
					lane_mem[wr_i.addr] <= wr_i.data[lane*8 +: 8];
				end
				rd_data_o[lane*8 +: 8] <= lane_mem[rd_addr_i];
			end
		end
	endgenerate

endmodule : ptp_slot_ram
`default_nettype wire

// File: sim/ptp_rtc_chk.sv
/* Checker for the APB answer and the receive event of the time counter block.
   Assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module ptp_rtc_chk (
	// Clock and reset
	input wire logic        clk_i,
	input wire logic        rst_b_i,
	// Watched ports
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        rx_frame_good_i,
	input wire logic [31:0] prdata_o,
	input wire logic        pready_o,
	input wire logic        pslverr_o,
	input wire logic        rx_ptp_irq_o
);
	logic [4:0] since_good;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	// Saturates so a stray event long after any frame still fails
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) since_good <= 5'h1F;
		else if (rx_frame_good_i) since_good <= 5'h00;
		else if (since_good != 5'h1F) since_good <= since_good + 5'h01;
	end
	a_quiet_reset: assert property ($rose(rst_b_i) |-> !pready_o && !rx_ptp_irq_o)
		else $error("output active right after reset");
	a_one_wait: assert property (psel_i && penable_i && !$past(penable_i) |-> !pready_o ##1 pready_o)
		else $error("answer not after exactly one wait");
	a_ready_pulse: assert property (pready_o |=> !pready_o)
		else $error("ready longer than one cycle");
	a_ready_access: assert property (pready_o |-> psel_i && penable_i && $past(penable_i))
		else $error("ready outside an access phase");
	a_err_ready: assert property (pslverr_o |-> pready_o)
		else $error("error without ready");
	a_err_zero: assert property (pslverr_o |-> prdata_o == 32'h0)
		else $error("refused read returns data");
	a_irq_pulse: assert property (rx_ptp_irq_o |=> !rx_ptp_irq_o)
		else $error("event longer than one cycle");
	a_irq_cause: assert property (rx_ptp_irq_o |-> since_good < 5'h0C)
		else $error("event without a good frame end");
	c_refused: cover property (pslverr_o);
	c_event: cover property (rx_ptp_irq_o);
	c_answer: cover property (pready_o && !pslverr_o);
endmodule : ptp_rtc_chk
bind ptp_rtc_rx_timestamp_buffer ptp_rtc_chk chk (.clk_i(clk_i), .rst_b_i(rst_b_i),
	.psel_i(psel_i), .penable_i(penable_i), .rx_frame_good_i(rx_frame_good_i),
	.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
	.rx_ptp_irq_o(rx_ptp_irq_o));
`default_nettype wire

// File: sim/rx_splitter_model.sv
/* Receive splitter model: clocks time frames out on the receive pins.
   Assumes the bench calls send_frame; the link clock stops between frames. */
`timescale 1ns/1ps
`default_nettype none
module rx_splitter_model (
	// Receive pins
	output var logic       rx_clk_o,
	output var logic       rx_en_o,
	output var logic [7:0] rx_data_o,
	output var logic       rx_valid_o,
	output var logic       rx_good_o,
	output var logic       rx_bad_o
);
	initial begin
		rx_clk_o = 1'b0;
		rx_en_o = 1'b0;
		rx_data_o = 8'h5A;
		rx_valid_o = 1'b0;
		rx_good_o = 1'b0;
		rx_bad_o = 1'b0;
	end
	// Pins change on the falling edge, 64 ns period
	task automatic cyc(input logic en, input logic [7:0] d, input logic v, g, b);
		rx_en_o = en;
		rx_data_o = d;
		rx_valid_o = v;
		rx_good_o = g;
		rx_bad_o = b;
		#32 rx_clk_o = 1'b1;
		#32 rx_clk_o = 1'b0;
	endtask : cyc
	// Only time frames are passed here
	task automatic send_frame(input logic [7:0] first, input int n, input logic ok);
		for (int i = 0; i < n; i++) begin
			cyc(1'b0, 8'hEE, 1'b1, 1'b0, 1'b0);
			cyc(1'b1, first + 8'(i), 1'b1, 1'b0, 1'b0);
		end
		cyc(1'b1, ~rx_data_o, 1'b0, ok, !ok);
		// Released data line returns to the last data byte
		cyc(1'b1, ~rx_data_o, 1'b0, 1'b0, 1'b0);
	endtask : send_frame
endmodule : rx_splitter_model
`default_nettype wire

// File: sim/test_ptp_rtc_rx_timestamp_buffer.sv
/* Self-checking bench: APB master, rtc clock pin and splitter model.
   Assumes the design answers every APB access and stamps with rtc stopped. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin error_cnt++; \
	$display("unexpected %s expected %h seen %h", nm, ex, gt); end end
module test_ptp_rtc_rx_timestamp_buffer
	import rtc_ptp_pkg::*;
;
	logic        clk_i = 1'b0, rst_b_i = 1'b0, rtc_clk_i = 1'b0, err;
	logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
	logic [11:0] paddr_i = 12'h000;
	logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
	logic        pready_o, pslverr_o, rx_ptp_irq_o;
	logic        rx_clk, rx_en, rx_valid, rx_good, rx_bad;
	logic [7:0]  rx_data;
	int          error_cnt = 0, checked = 0, cycles = 0, irq_cnt = 0;
	rx_splitter_model pm (.rx_clk_o(rx_clk), .rx_en_o(rx_en), .rx_data_o(rx_data),
		.rx_valid_o(rx_valid), .rx_good_o(rx_good), .rx_bad_o(rx_bad));
	ptp_rtc_rx_timestamp_buffer dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .rtc_clk_i(rtc_clk_i),
		.rx_clk_i(rx_clk), .rx_clk_en_i(rx_en), .rx_data_i(rx_data),
		.rx_data_valid_i(rx_valid), .rx_frame_good_i(rx_good), .rx_frame_bad_i(rx_bad),
		.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .rx_ptp_irq_o(rx_ptp_irq_o));
	// ------------------------------------------------------------------
	// Clock, event count and hang limit
	// ------------------------------------------------------------------
	initial forever #2.5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cycles++;
		if (rx_ptp_irq_o === 1'b1) irq_cnt++;
		if (cycles == 40000) begin
			error_cnt++;
			close_out();
		end
	end
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : close_out
	// ------------------------------------------------------------------
	// Bus and pin helpers
	// ------------------------------------------------------------------
	task automatic apb(input logic we, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_i);
		psel_i <= 1'b1;
		pwrite_i <= we;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do @(posedge clk_i); while (pready_o !== 1'b1);
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask : apb
	task automatic rdc(input logic [11:0] a, input logic [31:0] ex, input logic ee);
		apb(1'b0, a, 32'h0);
		`CHK("read data", ex, rd)
		`CHK("read error", ee, err)
	endtask : rdc
	task automatic tick;
		repeat (4) @(posedge clk_i);
		rtc_clk_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		rtc_clk_i <= 1'b0;
		repeat (8) @(posedge clk_i);
	endtask : tick
	task automatic snap(input logic [31:0] ns, lo, hi);
		apb(1'b1, CMD_ADDR, 32'h2);
		rdc(SNAP_NS_ADDR, ns, 1'b0);
		rdc(SNAP_SLO_ADDR, lo, 1'b0);
		rdc(SNAP_SHI_ADDR, hi, 1'b0);
	endtask : snap
	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_regs;
		rdc(INC_ADDR, 32'h0500_0000, 1'b0);
		rdc(LATEST_ADDR, 32'h0, 1'b0);
		rdc(12'h024, 32'h0, 1'b1);
		$display("test registers done");
	endtask : t_regs
	task automatic t_step;
		apb(1'b1, STEP_NS_ADDR, 32'h3B9A_C9F6);
		apb(1'b1, STEP_SLO_ADDR, 32'hFFFF_FFFF);
		apb(1'b1, STEP_SHI_ADDR, 32'h0000_FFFF);
		apb(1'b1, CMD_ADDR, 32'h1);
		snap(32'h3B9A_C9F6, 32'hFFFF_FFFF, 32'h0000_FFFF);
		tick();
		snap(32'h0000_0046, 32'h0, 32'h0);
		// Negative step borrows a second; step seconds still hold minus one
		apb(1'b1, STEP_NS_ADDR, 32'hFFFF_FF9C);
		apb(1'b1, CMD_ADDR, 32'h1);
		snap(32'h3B9A_C9E2, 32'hFFFF_FFFE, 32'h0000_FFFF);
		apb(1'b1, INC_ADDR, 32'h0018_0000);
		tick();
		tick();
		snap(32'h3B9A_C9E5, 32'hFFFF_FFFE, 32'h0000_FFFF);
		$display("test counter done");
	endtask : t_step
	task automatic frame(input logic [7:0] f, input logic ok, input logic [3:0] s);
		int b;
		logic [11:0] base;
		b = irq_cnt;
		base = 12'h800 + {1'b0, s, 7'h00};
		pm.send_frame(f, 4, ok);
		repeat (20) @(posedge clk_i);
		`CHK("event count", int'(ok), irq_cnt - b)
		rdc(LATEST_ADDR, {23'h0, 1'b1, 4'h0, s}, 1'b0);
		if (ok) begin
			rdc(base, {f + 8'h3, f + 8'h2, f + 8'h1, f}, 1'b0);
			rdc(base + 12'h078, 32'h3B9A_C9E5, 1'b0);
			rdc(base + 12'h07C, 32'h4, 1'b0);
		end
	endtask : frame
	task automatic t_frames;
		for (int k = 0; k < 17; k++) frame(8'(4 * k), 1'b1, 4'(k));
		rdc(12'h880, 32'h0706_0504, 1'b0);
		frame(8'hA0, 1'b0, 4'h0);
		frame(8'hB0, 1'b1, 4'h1);
		$display("test frames done");
	endtask : t_frames
	task automatic t_reset;
		// Positive step carries a second, then a mid-run reset restores increment, pointer and counter
		apb(1'b1, STEP_NS_ADDR, 32'h0000_0064);
		apb(1'b1, CMD_ADDR, 32'h1);
		snap(32'h0000_0049, 32'hFFFF_FFFE, 32'h0000_FFFF);
		@(posedge clk_i);
		rst_b_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		rst_b_i <= 1'b1;
		rdc(INC_ADDR, 32'h0500_0000, 1'b0);
		rdc(LATEST_ADDR, 32'h0, 1'b0);
		snap(32'h0, 32'h0, 32'h0);
		$display("test reset done");
	endtask : t_reset
	initial begin
		repeat (12) @(posedge clk_i);
		rst_b_i <= 1'b1;
		t_regs();
		t_step();
		t_frames();
		t_reset();
		close_out();
	end
endmodule : test_ptp_rtc_rx_timestamp_buffer
`default_nettype wire
